//--- hdl/aer_regs.sv
// Uncorrectable mask, uncorrectable severity and correctable status registers of one port.
// Assumes a single-cycle configuration access port on the core clock, byte offsets.
`timescale 1ns/1ps
`include "aer_regs_consts.svh"
module aer_regs
    import aer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [`AER_ADDR_W-1:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic [20:0] unc_err_i,
    input wire logic advisory_nonfatal_flag_i,
    input wire logic replay_timer_expired_i,
    input wire logic replay_rollover_i,
    input wire logic unacked_pending_i,
    input wire logic bad_link_packet_i,
    input wire logic bad_transaction_packet_i,
    input wire logic rx_decode_err_i,
    input wire logic msg_ready_i,
    output logic msg_valid_o,
    output logic msg_fatal_o,
    output logic [31:0] cor_status_o
);
    aer_bank_t cur;
    aer_bank_t next_cur;
    logic [31:0] be_bits;
    logic [31:0] unc_live;
    logic [31:0] cor_set;
    logic [31:0] cor_clr;
    logic [31:0] cor_status;
    logic wr_mask;
    logic wr_sev;
    logic wr_cor;

    aer_ev_if ev_if ();

    assign be_bits = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
    assign wr_mask = cfg_wr_i && (cfg_addr_i == `AER_OFS_UNC_MASK);
    assign wr_sev = cfg_wr_i && (cfg_addr_i == `AER_OFS_UNC_SEV);
    assign wr_cor = cfg_wr_i && (cfg_addr_i == `AER_OFS_COR_STATUS);

    always_comb begin
        next_cur = cur;
        next_cur.rvalid = cfg_rd_i;
        next_cur.rdata = '0;
        if (cfg_rd_i) begin
            // Reserved bits come back as zero; bit 0 reads zero in mask and severity, not in correctable status
            if (cfg_addr_i == `AER_OFS_UNC_MASK) begin
                next_cur.rdata = cur.mask & `AER_UNC_RW_BITS;
            end else if (cfg_addr_i == `AER_OFS_UNC_SEV) begin
                next_cur.rdata = cur.sev & `AER_UNC_RW_BITS;
            end else if (cfg_addr_i == `AER_OFS_COR_STATUS) begin
                next_cur.rdata = cor_status & `AER_COR_BITS;
            end else begin
                next_cur.rdata = '0;
            end
        end
        if (wr_mask) begin
            // Only the documented mask bits accept a write; bit 0 stays read-only
            next_cur.mask = (cur.mask & ~(be_bits & `AER_UNC_RW_BITS))
                | (cfg_wdata_i & be_bits & `AER_UNC_RW_BITS);
        end
        if (wr_sev) begin
            next_cur.sev = (cur.sev & ~(be_bits & `AER_UNC_RW_BITS))
                | (cfg_wdata_i & be_bits & `AER_UNC_RW_BITS);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur.mask <= `AER_UNC_MASK_RESET;
            cur.sev <= `AER_UNC_SEV_RESET;
            cur.rdata <= '0;
            cur.rvalid <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign cfg_rdata_o = cur.rdata;
    assign cfg_rvalid_o = cur.rvalid;

    // Only unmasked errors reach the message path; severity picks the kind
    assign unc_live = {11'h000, unc_err_i} & ~cur.mask & `AER_UNC_RW_BITS;
    assign ev_if.fatal = |(unc_live & cur.sev);
    assign ev_if.nonfatal = |(unc_live & ~cur.sev);

    always_comb begin
        cor_set = '0;
        cor_set[`AER_ADVISORY_NONFATAL_BIT] = advisory_nonfatal_flag_i;
        cor_set[`AER_REPLAY_TIMER_EXPIRED_BIT] =
            replay_timer_expired_i & unacked_pending_i;
        cor_set[`AER_REPLAY_ROLLOVER_BIT] = replay_rollover_i & unacked_pending_i;
        cor_set[`AER_BAD_LINK_PACKET_BIT] = bad_link_packet_i;
        cor_set[`AER_BAD_TRANSACTION_PACKET_BIT] = bad_transaction_packet_i;
        // Any decode error counts, whatever was being received
        cor_set[`AER_RX_DECODE_ERR_BIT] =
            rx_decode_err_i | bad_link_packet_i | bad_transaction_packet_i;
    end

    assign cor_clr = wr_cor ? (cfg_wdata_i & be_bits & `AER_COR_BITS) : '0;

    aer_sticky #(
        .W(32),
        .RESET_VAL(`AER_COR_STATUS_RESET)
    ) u_cor_status (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i(cor_set),
        .clr_i(cor_clr),
        .status_o(cor_status)
    );

    assign cor_status_o = cor_status;

    aer_msg_gen u_msg_gen (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ev(ev_if.snk),
        .msg_ready_i(msg_ready_i),
        .msg_valid_o(msg_valid_o),
        .msg_fatal_o(msg_fatal_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    mask_write_a: assert property ((wr_mask && cfg_be_i == 4'hf)
        |=> (cur.mask == ($past(cfg_wdata_i) & `AER_UNC_RW_BITS)))
        else $error("mask write not stored");
    sev_write_a: assert property ((wr_sev && cfg_be_i == 4'hf)
        |=> (cur.sev == ($past(cfg_wdata_i) & `AER_UNC_RW_BITS)))
        else $error("severity write not stored");
    read_rsvd_a: assert property (cfg_rvalid_o
        |-> ((cfg_rdata_o & ~(`AER_UNC_RW_BITS | `AER_COR_BITS)) == '0))
        else $error("reserved bits read nonzero");
    read_sev_a: assert property ((cfg_rd_i && cfg_addr_i == `AER_OFS_UNC_SEV && !wr_sev)
        |=> (cfg_rvalid_o && cfg_rdata_o == ($past(cur.sev) & `AER_UNC_RW_BITS)))
        else $error("severity read wrong");
    masked_quiet_a: assert property (((unc_err_i & cur.mask[20:0]) == unc_err_i)
        |-> (!ev_if.fatal && !ev_if.nonfatal))
        else $error("masked error produced a message");
    flow_fatal_a: assert property ((unc_err_i[`AER_FLOW_CTRL_BIT]
        && !cur.mask[`AER_FLOW_CTRL_BIT] && cur.sev[`AER_FLOW_CTRL_BIT])
        |=> (msg_valid_o && msg_fatal_o))
        else $error("fatal flow control error not reported");
    poison_nonfatal_a: assert property ((unc_err_i[`AER_POISONED_PKT_BIT]
        && !cur.mask[`AER_POISONED_PKT_BIT] && !cur.sev[`AER_POISONED_PKT_BIT])
        |-> ev_if.nonfatal)
        else $error("nonfatal poisoned error not classed nonfatal");
    replay_timer_a: assert property ((replay_timer_expired_i && unacked_pending_i)
        |=> cor_status[`AER_REPLAY_TIMER_EXPIRED_BIT])
        else $error("replay timeout not latched");
    replay_roll_a: assert property ((replay_rollover_i && unacked_pending_i)
        |=> cor_status[`AER_REPLAY_ROLLOVER_BIT])
        else $error("replay rollover not latched");
    bad_link_a: assert property (bad_link_packet_i
        |=> (cor_status[`AER_BAD_LINK_PACKET_BIT] && cor_status[`AER_RX_DECODE_ERR_BIT]))
        else $error("bad link packet not latched");
    bad_trans_a: assert property (bad_transaction_packet_i
        |=> cor_status[`AER_BAD_TRANSACTION_PACKET_BIT])
        else $error("bad transaction packet not latched");
    rx_decode_a: assert property (rx_decode_err_i |=> cor_status[`AER_RX_DECODE_ERR_BIT])
        else $error("decode error not latched");
    advisory_a: assert property ((cor_status[`AER_ADVISORY_NONFATAL_BIT] && !wr_cor)
        |=> cor_status[`AER_ADVISORY_NONFATAL_BIT])
        else $error("advisory flag dropped without a clear");

    fatal_msg_c: cover property (ev_if.fatal ##1 (msg_valid_o && msg_ready_i));
    masked_err_c: cover property ((unc_err_i != '0) && !ev_if.fatal && !ev_if.nonfatal);
    cor_clear_c: cover property (cor_status[`AER_RX_DECODE_ERR_BIT] && wr_cor
        && cfg_wdata_i[`AER_RX_DECODE_ERR_BIT]);
endmodule : aer_regs

//--- hdl/aer_regs_consts.svh
// Offsets, field positions, reset values and access masks of the error register bank.
// Assumes byte offsets into the port's extended configuration space.
`ifndef AER_REGS_CONSTS_SVH
`define AER_REGS_CONSTS_SVH

`define AER_ADDR_W 12
`define AER_OFS_UNC_MASK 12'h108
`define AER_OFS_UNC_SEV 12'h10c
`define AER_OFS_COR_STATUS 12'h110

`define AER_UNC_MASK_RESET 32'h0000_0000
`define AER_UNC_SEV_RESET 32'h0003_2030
`define AER_COR_STATUS_RESET 32'h0000_0000

// Writable bits of mask and severity: 20:12, 5, 4
`define AER_UNC_RW_BITS 32'h001f_f030
// Implemented correctable status bits: 13, 12, 8, 7, 6, 0
`define AER_COR_BITS 32'h0000_31c1

`define AER_FLOW_CTRL_BIT 13
`define AER_POISONED_PKT_BIT 12
`define AER_SURPRISE_DOWN_BIT 5
`define AER_LINK_PROTOCOL_BIT 4

`define AER_ADVISORY_NONFATAL_BIT 13
`define AER_REPLAY_TIMER_EXPIRED_BIT 12
`define AER_REPLAY_ROLLOVER_BIT 8
`define AER_BAD_LINK_PACKET_BIT 7
`define AER_BAD_TRANSACTION_PACKET_BIT 6
`define AER_RX_DECODE_ERR_BIT 0

`endif

//--- hdl/aer_pkg.sv
// Types shared by the error register bank modules.
// Assumes the constants header is included by the users.
package aer_pkg;

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] sev;
        logic [31:0] rdata;
        logic rvalid;
    } aer_bank_t;

    typedef struct packed {
        logic pend_fatal;
        logic pend_nonfatal;
    } aer_msg_t;

endpackage : aer_pkg

//--- hdl/aer_ev_if.sv
// Carrier for newly detected unmasked uncorrectable errors, sorted by severity.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface aer_ev_if;
    logic fatal;
    logic nonfatal;
    modport src (output fatal, output nonfatal);
    modport snk (input fatal, input nonfatal);
endinterface : aer_ev_if

//--- hdl/aer_sticky.sv
// Bank of sticky status bits: hardware sets, software clears by writing one.
// Assumes set and clear vectors are synchronous one-cycle requests.
`timescale 1ns/1ps
module aer_sticky #(
    parameter int W = 32,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] status_o
);
    typedef struct packed {
        logic [W-1:0] bits;
    } aer_sticky_t;

    aer_sticky_t cur;
    aer_sticky_t next_cur;

    // Set wins over a clear in the same cycle; writing zero leaves a bit alone
    always_comb begin
        next_cur = cur;
        next_cur.bits = (cur.bits & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur <= '{bits: RESET_VAL};
        end else begin
            cur <= next_cur;
        end
    end

    assign status_o = cur.bits;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    set_wins_a: assert property ((set_i != '0)
        |=> ((status_o & $past(set_i)) == $past(set_i)))
        else $error("sticky bit lost its set");
    clear_one_a: assert property (((clr_i & ~set_i) != '0)
        |=> ((status_o & $past(clr_i & ~set_i)) == '0))
        else $error("sticky bit not cleared by one");
    hold_zero_a: assert property ((set_i == '0 && clr_i == '0) |=> $stable(status_o))
        else $error("sticky bits changed without cause");
endmodule : aer_sticky

//--- hdl/aer_msg_gen.sv
// Queues ERR_FATAL and ERR_NONFATAL requests toward the upstream message path.
// Assumes the sink takes a message when valid and ready are both high.
`timescale 1ns/1ps
module aer_msg_gen
    import aer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    aer_ev_if.snk ev,
    input wire logic msg_ready_i,
    output logic msg_valid_o,
    output logic msg_fatal_o
);
    aer_msg_t cur;
    aer_msg_t next_cur;
    logic send;

    assign msg_valid_o = cur.pend_fatal | cur.pend_nonfatal;
    assign msg_fatal_o = cur.pend_fatal;
    assign send = msg_valid_o & msg_ready_i;

    // Fatal goes first; a new event in the send cycle stays pending
    always_comb begin
        next_cur = cur;
        if (send && cur.pend_fatal) begin
            next_cur.pend_fatal = 1'b0;
        end else if (send) begin
            next_cur.pend_nonfatal = 1'b0;
        end
        if (ev.fatal) begin
            next_cur.pend_fatal = 1'b1;
        end
        if (ev.nonfatal) begin
            next_cur.pend_nonfatal = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    fatal_msg_a: assert property (ev.fatal |=> (msg_valid_o && msg_fatal_o))
        else $error("fatal error not offered as ERR_FATAL");
    msg_hold_a: assert property ((msg_valid_o && !msg_ready_i)
        |=> (msg_valid_o && (msg_fatal_o || !$past(msg_fatal_o))))
        else $error("message dropped before it was taken");
    nonfatal_msg_a: assert property ((ev.nonfatal && !ev.fatal && !cur.pend_fatal)
        |=> (msg_valid_o && !msg_fatal_o))
        else $error("nonfatal error not offered as ERR_NONFATAL");
    both_sent_c: cover property (msg_valid_o && msg_fatal_o && cur.pend_nonfatal && msg_ready_i);
endmodule : aer_msg_gen

//--- tb/aer_up_sink.sv
// Upstream port model that takes error messages from the register bank.
// Assumes valid/ready transfers on the rising edge of the shared core clock.
`timescale 1ns/1ps
module aer_up_sink (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic stall_i,
    input wire logic msg_valid_i,
    input wire logic msg_fatal_i,
    output logic msg_ready_o,
    output int n_fatal_o,
    output int n_nonfatal_o
);
    // Slow mode: the bench holds off acceptance while stall_i is high
    assign msg_ready_o = !stall_i;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            n_fatal_o <= 0;
            n_nonfatal_o <= 0;
        end else if (msg_valid_i && msg_ready_o) begin
            if (msg_fatal_i) begin
                n_fatal_o <= n_fatal_o + 1;
            end else begin
                n_nonfatal_o <= n_nonfatal_o + 1;
            end
        end
    end
endmodule : aer_up_sink

//--- tb/aer_regs_tb.sv
// Self-checking bench of the error register bank with an upstream message sink.
// Assumes the design and constants header from hdl/ are compiled first.
`timescale 1ns/1ps
`include "aer_regs_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module aer_regs_tb;
    import aer_pkg::*;
    typedef struct {logic wr; logic [11:0] a; logic [3:0] be;
        logic [31:0] d; logic [31:0] e;} aer_row_t;
    logic clk_i, rst_b_i, cfg_rd_i, cfg_wr_i, unacked, stall;
    logic [11:0] cfg_addr_i;
    logic [3:0] cfg_be_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, cor_status_o, rd, sevv;
    logic cfg_rvalid_o, msg_valid_o, msg_fatal_o, msg_ready;
    logic [20:0] unc;
    logic [5:0] ev;
    int n_fatal, n_nonfatal, miscompares, total_checks, nf, nn;
    aer_row_t rows[11] = '{
        '{0, 12'h108, 4'h0, 32'h0, 32'h0}, '{0, 12'h10c, 4'h0, 32'h0, 32'h0003_2030},
        '{0, 12'h110, 4'h0, 32'h0, 32'h0}, '{0, 12'h114, 4'h0, 32'h0, 32'h0},
        '{1, 12'h108, 4'hf, 32'hffff_ffff, 32'h001f_f030}, '{1, 12'h108, 4'hf, 32'h0, 32'h0},
        '{1, 12'h10c, 4'hf, 32'hffff_ffff, 32'h001f_f030},
        '{1, 12'h10c, 4'h1, 32'h0, 32'h001f_f000}, '{1, 12'h10c, 4'hf, 32'h0, 32'h0},
        '{1, 12'h110, 4'hf, 32'hffff_ffff, 32'h0}, '{1, 12'h114, 4'hf, 32'hffff_ffff, 32'h0}};
    logic [31:0] cexp[6] = '{32'h2000, 32'h1000, 32'h0100, 32'h0081, 32'h0041, 32'h0001};
    int ubits[11] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 5, 4};

    aer_regs i_aer_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_rd_i(cfg_rd_i),
        .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .unc_err_i(unc), .advisory_nonfatal_flag_i(ev[0]), .replay_timer_expired_i(ev[1]),
        .replay_rollover_i(ev[2]), .unacked_pending_i(unacked), .bad_link_packet_i(ev[3]),
        .bad_transaction_packet_i(ev[4]), .rx_decode_err_i(ev[5]), .msg_ready_i(msg_ready),
        .msg_valid_o(msg_valid_o), .msg_fatal_o(msg_fatal_o), .cor_status_o(cor_status_o));
    aer_up_sink i_aer_up_sink (.clk_i(clk_i), .rst_b_i(rst_b_i), .stall_i(stall),
        .msg_valid_i(msg_valid_o), .msg_fatal_i(msg_fatal_o), .msg_ready_o(msg_ready),
        .n_fatal_o(n_fatal), .n_nonfatal_o(n_nonfatal));

    always #4 clk_i = ~clk_i;

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic cfg_wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_be_i = be;
        cfg_wdata_i = d;
        tick();
        cfg_wr_i = 1'b0;
    endtask : cfg_wr

    task automatic cfg_rd(input logic [11:0] a, output logic [31:0] d);
        cfg_rd_i = 1'b1;
        cfg_addr_i = a;
        tick();
        cfg_rd_i = 1'b0;
        `CHK("rvalid", 1'b1, cfg_rvalid_o)
        d = cfg_rdata_o;
    endtask : cfg_rd

    // Waits a bounded time for the sink to have taken tgt messages in all
    task automatic wait_tot(input int tgt);
        int t;
        for (t = 0; t < 10 && n_fatal + n_nonfatal < tgt; t++) begin
            tick();
        end
        if (t == 10) begin
            miscompares++;
            $display("BAD message wait exp %0d got %0d", tgt, n_fatal + n_nonfatal);
            give_verdict();
        end
    endtask : wait_tot

    task automatic pulse_unc(input logic [20:0] v);
        unc = v;
        tick();
        unc = '0;
    endtask : pulse_unc

    initial begin
        clk_i = 1'b0;
        rst_b_i = 1'b0;
        {cfg_rd_i, cfg_wr_i, unacked, stall} = '0;
        cfg_addr_i = '0;
        cfg_be_i = '0;
        cfg_wdata_i = '0;
        unc = '0;
        ev = '0;
        repeat (6) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        tick();
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                cfg_wr(rows[i].a, rows[i].be, rows[i].d);
            end
            cfg_rd(rows[i].a, rd);
            sevv = (rows[i].a == 12'h110) ? 32'hffff_ffff : 32'hffff_fffe;
            `CHK("reg read", rows[i].e & sevv, rd & sevv)
            tick();
            `CHK("rvalid pulse", 1'b0, cfg_rvalid_o)
            `CHK("idle rdata", 32'h0, cfg_rdata_o)
        end
        $display("done register table");
        unacked = 1'b1;
        for (int k = 0; k < 6; k++) begin
            ev = 6'(1 << k);
            tick();
            ev = '0;
            `CHK("cor set", cexp[k], cor_status_o)
            cfg_wr(12'h110, 4'hf, 32'h0);
            cfg_rd(12'h110, rd);
            `CHK("cor keep", cexp[k], rd)
            cfg_wr(12'h110, 4'hf, cexp[k]);
            `CHK("cor clear", 32'h0, cor_status_o)
        end
        unacked = 1'b0;
        ev = 6'h06;
        tick();
        ev = 6'h20;
        `CHK("no unacked", 32'h0, cor_status_o)
        cfg_wr(12'h110, 4'hf, 32'h1);
        ev = '0;
        `CHK("set over clear", 32'h1, cor_status_o)
        tick();
        cfg_wr(12'h110, 4'hf, 32'h1);
        $display("done correctable status");
        for (int p = 0; p < 2; p++) begin
            sevv = p ? (`AER_UNC_RW_BITS ^ `AER_UNC_SEV_RESET) : `AER_UNC_SEV_RESET;
            cfg_wr(12'h10c, 4'hf, sevv);
            foreach (ubits[j]) begin
                nf = n_fatal;
                nn = n_nonfatal;
                pulse_unc(21'(1 << ubits[j]));
                wait_tot(nf + nn + 1);
                `CHK("fatal count", nf + int'(sevv[ubits[j]]), n_fatal)
                `CHK("nonfatal count", nn + int'(!sevv[ubits[j]]), n_nonfatal)
            end
        end
        $display("done severity messages");
        cfg_wr(12'h10c, 4'hf, `AER_UNC_SEV_RESET);
        tick();
        cfg_wr(12'h108, 4'hf, 32'h2000);
        pulse_unc(21'h2000);
        repeat (3) begin
            tick();
            `CHK("masked valid", 1'b0, msg_valid_o)
        end
        cfg_wr(12'h108, 4'hf, 32'h0);
        $display("done mask");
        nf = n_fatal;
        nn = n_nonfatal;
        stall = 1'b1;
        pulse_unc(21'h3000);
        repeat (2) begin
            tick();
            `CHK("stalled valid", 1'b1, msg_valid_o)
            `CHK("fatal first", 1'b1, msg_fatal_o)
        end
        stall = 1'b0;
        wait_tot(nf + nn + 2);
        `CHK("both sent", nf + nn + 2, n_fatal + n_nonfatal)
        `CHK("one fatal", nf + 1, n_fatal)
        $display("done stalled upstream");
        ev = 6'h20;
        cfg_wr(12'h10c, 4'hf, 32'h0);
        ev = '0;
        rst_b_i = 1'b0;
        #1;
        `CHK("reset status", 32'h0, cor_status_o)
        repeat (6) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        tick();
        cfg_rd(12'h10c, rd);
        `CHK("reset sev", `AER_UNC_SEV_RESET & 32'hffff_fffe, rd & 32'hffff_fffe)
        $display("done mid-run reset");
        give_verdict();
    end
endmodule : aer_regs_tb
